// ### bench/fsr2_chk.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level relations of the status block
module fsr2_chk (
    input wire logic                 hclk,
    input wire logic                 hresetn,
    input wire logic                 hsel,
    input wire logic [1:0]           htrans,
    input wire logic                 hwrite,
    input wire logic                 hready,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic [31:0]          hrdata,
    input wire fsr2_pkg::fsr2_pins_t pins,
    input wire logic                 quad_io,
    input wire logic                 pin_fn,
    input wire logic                 suspended,
    input wire logic [15:0]          prot_eff
);
    import fsr2_pkg::*;
    logic       taken;    // transfer accepted
    logic       wr_dp_r;  // write data phase
    logic [3:0] wr_age_r; // cycles since a write data phase
    logic [3:0] cs_hi_r;  // cycles with chip select high
    assign taken = hsel & htrans[1] & hready;
    // saturating age counters bound the windows for mode changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dp_r  <= 1'b0;
            wr_age_r <= 4'hF;
            cs_hi_r  <= 4'hF;
        end else begin
            wr_dp_r  <= taken & hwrite;
            wr_age_r <= wr_dp_r ? 4'h0 : ((wr_age_r == 4'hF) ? 4'hF : wr_age_r + 4'h1);
            cs_hi_r  <= !pins.cs_n ? 4'h0 : ((cs_hi_r == 4'hF) ? 4'hF : cs_hi_r + 4'h1);
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_read_wait: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (taken && hwrite |=> hreadyout)
        else $error("write stalled");
    a_rdata_hold: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
        else $error("read data moved outside a read");
    a_pin_mode: assert property (pin_fn == !quad_io)
        else $error("pin function and data mode disagree");
    a_quad_cause: assert property ($changed(quad_io) |-> wr_age_r <= 4'h3)
        else $error("data mode changed without a write");
    a_prot_cause: assert property ($changed(prot_eff) |-> wr_age_r <= 4'h3)
        else $error("protection map changed without a write");
    a_suspend_flag_rise: assert property ($rose(suspended) |-> cs_hi_r >= 4'h1 && cs_hi_r <= 4'h8)
        else $error("suspend set outside a frame end");
endmodule
bind fsr2_top fsr2_chk u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .pins, .quad_io, .pin_fn, .suspended, .prot_eff);

// ### bench/fsr2_host_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// serial host: opcode frames at a 200 ns serial clock, plus the two pin levels
module fsr2_host_model (
    input  wire logic             hclk,
    output fsr2_pkg::fsr2_pins_t  pins
);
    import fsr2_pkg::*;
    // idle: clock parked low, chip select high, control pins inactive
    initial pins = '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0, wp_n: 1'b1, hold_n: 1'b1};
    // one whole opcode, msb first; clock stands still outside the frame
    task automatic frame(input logic [7:0] op);
        pins.cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pins.si <= op[i];
            repeat (4) @(posedge hclk);
            pins.sclk <= 1'b1;
            repeat (4) @(posedge hclk);
            pins.sclk <= 1'b0;
        end
        repeat (4) @(posedge hclk);
        pins.cs_n <= 1'b1;
        // data line no longer valid: show the inverse
        pins.si <= ~op[0];
        repeat (8) @(posedge hclk);
    endtask
    // write protect and hold levels, then time to settle through the sync
    task automatic pin(input logic wp, input logic hold);
        pins.wp_n   <= wp;
        pins.hold_n <= hold;
        repeat (8) @(posedge hclk);
    endtask
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// bus master, serial host and scenario sequence
module tb_top;
    import fsr2_pkg::*;
    logic        hclk = 1'b0;     // 40 MHz
    logic        hresetn = 1'b0;  // async reset
    logic        hsel = 1'b0;     // select
    logic        hwrite = 1'b0;   // direction
    logic [1:0]  htrans = 2'h0;   // transfer kind
    logic [2:0]  hsize = 3'h0;    // transfer size
    logic [31:0] haddr = 32'h0;   // address
    logic [31:0] hwdata = 32'h0;  // write data
    logic [31:0] q;               // last read word
    logic        hreadyout, hresp, quad_io, pin_fn, suspended;
    logic [31:0] hrdata;          // read data
    logic [15:0] prot_eff;        // effective map
    fsr2_pins_t  pins;            // link pins
    int          n_mismatch = 0;
    int          compares = 0;
    always #12.5 hclk = ~hclk;
    fsr2_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
        .quad_io(quad_io), .pin_fn(pin_fn), .suspended(suspended), .prot_eff(prot_eff));
    fsr2_host_model u_host (.hclk(hclk), .pins(pins));
    ////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic results();
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one word compare
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // wait for ready as sampled at a rising edge, bounded
    task automatic phase(output logic [31:0] d);
        int n;
        logic r;
        n = 0;
        do begin
            // values as they stood at this rising edge
            @(posedge hclk);
            r = hreadyout;
            d = hrdata;
            n++;
        end while (r !== 1'b1 && n < 40);
        if (r !== 1'b1) begin
            n_mismatch++;
            results();
        end
    endtask
    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        haddr  <= {27'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        hsize  <= 3'h2;
        hsel   <= 1'b1;
        phase(q);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= {16'h0, d};
        phase(q);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] e, input string nm);
        bus(1'b0, a, 16'h0);
        chk(nm, {16'h0, e}, q);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // reset values, lock view, unmapped place
    task automatic t_defaults();
        rd(5'h00, 16'h0000, "status");
        rd(5'h14, 16'h0100, "flags");
        rd(5'h18, 16'h0000, "unmapped");
        chk("pin_fn", 32'(pin_fn), 32'h1);
    endtask
    // writable fields land, read-only ones hold; complement inverts the map
    task automatic t_fields();
        wr(5'h04, 16'h0002);
        wr(5'h00, 16'h00FF);
        rd(5'h00, 16'h0043, "status");
        chk("quad_io", 32'(quad_io), 32'h1);
        wr(5'h08, 16'h8000);
        rd(5'h0C, 16'h7FFF, "prot_eff");
        chk("prot_eff_out", 32'(prot_eff), 32'h7FFF);
    endtask
    // lock-down until software reset, suspend cleared by that reset
    task automatic t_lockdown();
        wr(5'h04, 16'h0002);
        wr(5'h00, 16'h0000);
        rd(5'h00, 16'h0043, "status");
        rd(5'h14, 16'h0101, "flags");
        wr(5'h14, 16'h0001);
        u_host.frame(8'h75);
        rd(5'h00, 16'h00C3, "status");
        u_host.frame(8'h66);
        u_host.frame(8'h99);
        rd(5'h00, 16'h0042, "status");
    endtask
    // resume, quad opcodes allowed then refused, hold pin reset
    task automatic t_quad();
        logic [7:0] ops [6] = '{8'h6B, 8'hEB, 8'hE7, 8'h32, 8'h77, 8'h94};
        u_host.frame(8'h75);
        u_host.frame(8'h7A);
        chk("suspended", 32'(suspended), 32'h0);
        u_host.frame(8'hEB);
        rd(5'h14, 16'h0100, "flags");
        wr(5'h04, 16'h0002);
        wr(5'h00, 16'h0000);
        rd(5'h0C, 16'h8000, "prot_eff");
        foreach (ops[i]) begin
            u_host.frame(ops[i]);
            rd(5'h14, 16'h0104, "flags");
            wr(5'h14, 16'h0004);
        end
        u_host.frame(8'h75);
        u_host.pin(1'b1, 1'b0);
        u_host.pin(1'b1, 1'b1);
        chk("suspended", 32'(suspended), 32'h0);
    endtask
    // write protect pin, one-time locks, permanent protection
    task automatic t_locks();
        wr(5'h04, 16'h0002);
        wr(5'h04, 16'h0001);
        u_host.pin(1'b0, 1'b1);
        wr(5'h04, 16'h0002);
        wr(5'h00, 16'h0002);
        rd(5'h00, 16'h0000, "status");
        u_host.pin(1'b1, 1'b1);
        wr(5'h04, 16'h0002);
        wr(5'h00, 16'h0002);
        rd(5'h00, 16'h0002, "status");
        wr(5'h10, 16'h7E02);
        wr(5'h10, 16'h7F01);
        wr(5'h10, 16'h7F03);
        wr(5'h10, 16'h7F00);
        rd(5'h00, 16'h002A, "status");
        rd(5'h14, 16'h0B03, "flags");
        wr(5'h14, 16'h0002);
        wr(5'h10, 16'h0001);
        rd(5'h14, 16'h0B03, "flags");
        wr(5'h04, 16'h0002);
        wr(5'h04, 16'h0005);
        wr(5'h04, 16'h0002);
        wr(5'h00, 16'h00FF);
        rd(5'h00, 16'h006B, "status");
        u_host.frame(8'h66);
        u_host.frame(8'h99);
        rd(5'h00, 16'h006B, "status");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_defaults();
        t_fields();
        t_lockdown();
        t_quad();
        t_locks();
        results();
    end
endmodule

// ### design/fsr2_defines.svh
// What this block does
// - suspend opcode 75h sets suspend flag bit 7
// - resume 7Ah, resets, 66h/99h clear suspend flag
// - complement protect bit 6, default 0
// - complement set inverts the protection map
// - bits 5:3 read-only lock field, default 000
// - bit 5 reg 3, bit 4 reg 2, bit 3 reg 1
// - programming byte 127 sets its lock bit
// - locked register read-only, lock never clears
// - security register 0 always locked, no bit
// - quad enable bit 1, default 0, enables quad
// - quad off: pins keep protect and hold functions
// - quad on: pins become data lines 2 and 3
// - quad enable gates six quad opcodes only
// - bit 0 upper status-protect, default 0
// - status-protect bits are volatile
// - protect 00: writes need latch, pin ignored
// - protect 01: pin low rejects, high accepts
// - protect 10: writes blocked until reset
// - protect 11: until reset, or forever if locked
`ifndef FSR2_DEFINES_SVH
`define FSR2_DEFINES_SVH
// register byte offsets
`define FSR2_OFS_STATUS2  5'h00
`define FSR2_OFS_CTRL     5'h04
`define FSR2_OFS_PMAP     5'h08
`define FSR2_OFS_PEFF     5'h0C
`define FSR2_OFS_OTPPROG  5'h10
`define FSR2_OFS_FLAGS    5'h14
// status register two field positions
`define FSR2_B_SUSPEND_FLAG       7
`define FSR2_B_COMPLEMENT_PROTECT      6
`define FSR2_B_QE         1
`define FSR2_B_SRPHI      0
// control register field positions
`define FSR2_B_SRPLO      0
`define FSR2_B_WEL        1
`define FSR2_B_STATUS_LOCK_BIT     2
// flags register field positions
`define FSR2_B_WRREF      0
`define FSR2_B_OTPREF     1
`define FSR2_B_CMDREF     2
// reset values
`define FSR2_RST_STATUS2  8'h00
`define FSR2_RST_PMAP     16'h0000
// opcodes
`define FSR2_OP_SUSPEND   8'h75
`define FSR2_OP_RESUME    8'h7A
`define FSR2_OP_RSTEN     8'h66
`define FSR2_OP_RST       8'h99
`define FSR2_OP_QOREAD    8'h6B
`define FSR2_OP_XIPREAD   8'hEB
`define FSR2_OP_XIPREADW  8'hE7
`define FSR2_OP_QPROG     8'h32
`define FSR2_OP_WRAP      8'h77
`define FSR2_OP_QID       8'h94
// last byte index of a 128-byte security register
`define FSR2_OTP_LAST     7'h7F
`endif

// ### design/fsr2_pkg.sv
package fsr2_pkg;
    // pin synchroniser lanes
    typedef struct packed {
        logic sclk;   // serial clock
        logic cs_n;   // chip select
        logic si;     // serial data in
        logic wp_n;   // write protect pin
        logic hold_n; // hold or reset pin
    } fsr2_pins_t;

    // whole state of the block
    typedef struct packed {
        fsr2_pins_t  sy1;         // first sync stage
        fsr2_pins_t  sy2;         // second sync stage
        logic        sclk_d;      // sclk of previous cycle
        logic        cs_n_d;      // cs of previous cycle
        logic [2:0]  bitcnt;      // bits of opcode shifted
        logic [7:0]  shreg;       // opcode shifter
        logic        full;        // whole opcode received
        logic        rst_armed;   // reset enable seen
        logic        suspend_flag;        // suspend flag
        logic        complement_protect;       // complement protect
        logic        qe;          // quad enable
        logic        srp_hi;      // upper status protect
        logic        srp_lo;      // lower status protect
        logic        write_enable_latch;         // write enable latch
        logic        status_lock_bit;      // status lock bit
        logic [2:0]  otp_lock;    // lock bits regs 3..1
        logic [15:0] pmap;        // configured protect map
        logic [15:0] peff;        // effective protect map
        logic        wr_ref;      // status write refused
        logic        otp_ref;     // otp program refused
        logic        cmd_ref;     // quad opcode refused
        logic        rd_pend;     // read data phase
        logic        wr_pend;     // write data phase
        logic [4:0]  addr;        // latched address
        logic        hreadyout;   // bus ready
        logic [31:0] hrdata;      // bus read data
        logic        quad_io;     // pins in data mode
        logic        pin_fn;      // pins in control mode
    } fsr2_state_t;
endpackage

// ### design/fsr2_top.sv
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "fsr2_defines.svh"

module fsr2_top (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    input  wire fsr2_pkg::fsr2_pins_t pins,
    output logic                   quad_io,
    output logic                   pin_fn,
    output logic                   suspended,
    output logic [15:0]            prot_eff
);
    import fsr2_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state and derived terms
    fsr2_state_t st_r;          // registered state
    fsr2_state_t st_nxt;        // next state
    logic        sclk_rise;     // link clock rising edge
    logic        cs_rise;       // end of a frame
    logic        hw_rst;        // reset from hold pin
    logic        sw_rst;        // 66h then 99h
    logic        wp_high;       // protect pin reads high
    logic        wr_ok;         // status write allowed
    logic        addr_ok;       // bus address phase taken
    logic [7:0]  status2;       // status two read view
    logic [31:0] rd_mux;        // read data selection
    logic        quad_op;       // opcode needs quad enable

    ////////////////////////////////////////////////////////////////////
    // combinational helpers
    always_comb begin
        // edges seen on the synchronised link pins
        sclk_rise = st_r.sy2.sclk & ~st_r.sclk_d & ~st_r.sy2.cs_n;
        cs_rise   = st_r.sy2.cs_n & ~st_r.cs_n_d;
        // hold pin resets only while it is a control pin
        hw_rst    = ~st_r.qe & ~st_r.sy2.hold_n;
        sw_rst    = cs_rise & st_r.full & st_r.rst_armed
                    & (st_r.shreg == `FSR2_OP_RST);
        // with quad on, the protect function is off
        wp_high   = st_r.qe | st_r.sy2.wp_n;
        // protection decode of the status-protect pair
        case ({st_r.srp_hi, st_r.srp_lo})
            2'b00:   wr_ok = st_r.write_enable_latch;
            2'b01:   wr_ok = st_r.write_enable_latch & wp_high;
            2'b10:   wr_ok = 1'b0;
            default: wr_ok = 1'b0;
        endcase
        // opcodes that only run with quad enabled
        case (st_r.shreg)
            `FSR2_OP_QOREAD, `FSR2_OP_XIPREAD, `FSR2_OP_XIPREADW,
            `FSR2_OP_QPROG, `FSR2_OP_WRAP, `FSR2_OP_QID:
                quad_op = 1'b1;
            default:
                quad_op = 1'b0;
        endcase
        // bit 2 reserved, reads zero
        status2 = {st_r.suspend_flag, st_r.complement_protect, st_r.otp_lock, 1'b0,
                   st_r.qe, st_r.srp_hi};
        addr_ok = hsel & htrans[1] & hready;
        // read mux, unmapped offsets read zero
        case (st_r.addr)
            `FSR2_OFS_STATUS2: rd_mux = {24'h00_0000, status2};
            `FSR2_OFS_CTRL:    rd_mux = {29'h0000_0000, st_r.status_lock_bit,
                                         st_r.write_enable_latch, st_r.srp_lo};
            `FSR2_OFS_PMAP:    rd_mux = {16'h0000, st_r.pmap};
            `FSR2_OFS_PEFF:    rd_mux = {16'h0000, st_r.peff};
            `FSR2_OFS_FLAGS:   rd_mux = {20'h0_0000, st_r.otp_lock, 1'b1,
                                         5'h00, st_r.cmd_ref,
                                         st_r.otp_ref, st_r.wr_ref};
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_nxt = st_r;
        // two-flop synchronisers, first stage read only by second
        st_nxt.sy1    = pins;
        st_nxt.sy2    = st_r.sy1;
        st_nxt.sclk_d = st_r.sy2.sclk;
        st_nxt.cs_n_d = st_r.sy2.cs_n;

        // opcode shifter, restarts while chip select is high
        if (st_r.sy2.cs_n) begin
            st_nxt.bitcnt = 3'd0;
        end else if (sclk_rise && !st_r.full) begin
            st_nxt.shreg  = {st_r.shreg[6:0], st_r.sy2.si};
            st_nxt.bitcnt = st_r.bitcnt + 3'd1;
            st_nxt.full   = (st_r.bitcnt == 3'd7);
        end

        // complete opcodes act at the end of their frame
        if (cs_rise) begin
            st_nxt.full = 1'b0;
            if (st_r.full) begin
                st_nxt.rst_armed = (st_r.shreg == `FSR2_OP_RSTEN);
                if (st_r.shreg == `FSR2_OP_SUSPEND) begin
                    st_nxt.suspend_flag = 1'b1;
                end
                if (st_r.shreg == `FSR2_OP_RESUME) begin
                    st_nxt.suspend_flag = 1'b0;
                end
                if (quad_op && !st_r.qe) begin
                    st_nxt.cmd_ref = 1'b1;
                end
            end
        end

        // bus address phase, reads take one wait state
        st_nxt.wr_pend   = 1'b0;
        st_nxt.rd_pend   = 1'b0;
        st_nxt.hreadyout = 1'b1;
        if (st_r.rd_pend) begin
            st_nxt.hrdata = rd_mux;
        end
        if (addr_ok) begin
            st_nxt.addr    = {haddr[4:2], 2'b00};
            st_nxt.wr_pend = hwrite;
            st_nxt.rd_pend = ~hwrite;
            if (!hwrite) begin
                st_nxt.hreadyout = 1'b0;
            end
        end

        // bus write data phase
        if (st_r.wr_pend) begin
            case (st_r.addr)
                `FSR2_OFS_STATUS2: begin
                    // read-only bits are left alone
                    if (wr_ok) begin
                        st_nxt.complement_protect  = hwdata[`FSR2_B_COMPLEMENT_PROTECT];
                        st_nxt.qe     = hwdata[`FSR2_B_QE];
                        st_nxt.srp_hi = hwdata[`FSR2_B_SRPHI];
                        st_nxt.write_enable_latch    = 1'b0;
                    end else begin
                        st_nxt.wr_ref = 1'b1;
                    end
                end
                `FSR2_OFS_CTRL: begin
                    if (hwdata[`FSR2_B_WEL]) begin
                        // write enable, no other effect
                        st_nxt.write_enable_latch = 1'b1;
                    end else if (wr_ok) begin
                        st_nxt.srp_lo = hwdata[`FSR2_B_SRPLO];
                        st_nxt.status_lock_bit = st_r.status_lock_bit
                                        | hwdata[`FSR2_B_STATUS_LOCK_BIT];
                        st_nxt.write_enable_latch    = 1'b0;
                    end else begin
                        st_nxt.wr_ref = 1'b1;
                    end
                end
                `FSR2_OFS_PMAP: begin
                    st_nxt.pmap = hwdata[15:0];
                end
                `FSR2_OFS_OTPPROG: begin
                    // register 0 and locked registers refuse
                    if (hwdata[1:0] == 2'd0) begin
                        st_nxt.otp_ref = 1'b1;
                    end else if (st_r.otp_lock[hwdata[1:0] - 2'd1]) begin
                        st_nxt.otp_ref = 1'b1;
                    end else if (hwdata[14:8] == `FSR2_OTP_LAST) begin
                        st_nxt.otp_lock[hwdata[1:0] - 2'd1] = 1'b1;
                    end
                end
                `FSR2_OFS_FLAGS: begin
                    // write one to clear, a new event wins
                    // only a quad opcode refusal can land in the same cycle as this write
                    st_nxt.wr_ref  = st_r.wr_ref & ~hwdata[`FSR2_B_WRREF];
                    st_nxt.otp_ref = st_r.otp_ref & ~hwdata[`FSR2_B_OTPREF];
                    st_nxt.cmd_ref = (st_r.cmd_ref & ~hwdata[`FSR2_B_CMDREF])
                                     | (cs_rise & st_r.full & quad_op
                                        & ~st_r.qe);
                end
                default: begin
                    // unmapped or read-only, ignored
                end
            endcase
        end

        // hardware or software reset of the volatile bits
        if (hw_rst || sw_rst) begin
            st_nxt.suspend_flag      = 1'b0;
            st_nxt.write_enable_latch       = 1'b0;
            st_nxt.rst_armed = 1'b0;
            // lockdown ends, unless locked for good
            if (!(st_r.status_lock_bit && st_r.srp_hi && st_r.srp_lo)) begin
                st_nxt.srp_hi = 1'b0;
                st_nxt.srp_lo = 1'b0;
            end
        end

        // effective map, inverted under complement
        st_nxt.peff    = st_r.complement_protect ? ~st_r.pmap : st_r.pmap;
        st_nxt.quad_io = st_r.qe;
        st_nxt.pin_fn  = ~st_r.qe;
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r           <= '0;
            st_r.sy1       <= 5'h1F;
            st_r.sy2       <= 5'h1F;
            st_r.sclk_d    <= 1'b1;
            st_r.cs_n_d    <= 1'b1;
            st_r.pmap      <= `FSR2_RST_PMAP;
            st_r.peff      <= `FSR2_RST_PMAP;
            st_r.hreadyout <= 1'b1;
            st_r.pin_fn    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from the state register, hresp tied low
    assign hreadyout = st_r.hreadyout;
    assign hrdata    = st_r.hrdata;
    assign hresp     = 1'b0;
    assign quad_io   = st_r.quad_io;
    assign pin_fn    = st_r.pin_fn;
    assign suspended = st_r.suspend_flag;
    assign prot_eff  = st_r.peff;

endmodule
